// ==== pkg/mrb_regs.vh ====
`ifndef MRB_REGS_VH
`define MRB_REGS_VH
// Register byte offsets
`define MRB_A_CTRL 8'h00
`define MRB_A_AGE 8'h04
`define MRB_A_LIMIT 8'h08
`define MRB_A_PASS 8'h0c
`define MRB_A_NLEN 8'h10
`define MRB_A_CLEN 8'h14
`define MRB_A_STAT 8'h18
`define MRB_A_NUM0 8'h20
`define MRB_A_NUM6 8'h38
`define MRB_A_CON0 8'h40
`define MRB_A_CON1 8'h44
`define MRB_A_COF0 8'h48
`define MRB_A_COF1 8'h4c
// Control fields
`define MRB_C_WORD 0
`define MRB_C_ACK 1
`define MRB_C_RET 2
`define MRB_C_PWP 3
// Reset values
`define MRB_RST_CTRL 4'h0
`define MRB_RST_AGE 10'h001
`define MRB_RST_LIMIT 32'h7fff8000
`define MRB_RST_PASS 16'h0000
// Age range units in minutes
`define MRB_U_MIN 14'h0005
`define MRB_U_HALF 14'h001e
`define MRB_U_DAY 14'h05a0
`define MRB_U_WEEK 14'h2760
// Characters
`define MRB_CH_STAR 8'h2a
`define MRB_CH_PLUS 8'h2b
`define MRB_CH_COMMA 8'h2c
`define MRB_CH_MINUS 8'h2d
`define MRB_CH_EQ 8'h3d
`define MRB_CH_0 8'h30
`define MRB_CH_9 8'h39
// Reply codes
`define MRB_ACK_OK 2'h0
`define MRB_ACK_ERR 2'h1
`define MRB_ACK_NOACC 2'h2
// Response codes
`define MRB_RESP_OK 2'h0
`define MRB_RESP_SLV 2'h2
`endif

// ==== design/mrb_top.v ====
`timescale 1ns/1ps
`default_nettype none
`include "mrb_regs.vh"
module mrb_top (
  input wire CLK_SYS,
  input wire RST,
  input wire [7:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output reg S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output reg S_AXI_WREADY,
  output reg [1:0] S_AXI_BRESP,
  output reg S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire [7:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output reg S_AXI_ARREADY,
  output reg [31:0] S_AXI_RDATA,
  output reg [1:0] S_AXI_RRESP,
  output reg S_AXI_RVALID,
  input wire S_AXI_RREADY,
  input wire ENABLE,
  input wire RESET_IN,
  input wire RUN,
  input wire PWR_RESTORE,
  input wire MSG_NEW,
  output reg XFER_REQ,
  input wire MSG_VALID,
  output reg MSG_READY,
  input wire MSG_FIELD,
  input wire [7:0] MSG_CHAR,
  input wire MSG_LAST,
  input wire [19:0] MSG_AGE,
  output reg ERASE_REQ,
  output reg ACK_VALID,
  output reg [1:0] ACK_CODE,
  input wire ACK_READY,
  output reg BIT_OUT,
  output reg [15:0] WORD_OUT
);
  localparam ST_IDLE = 3'd0;
  localparam ST_RECV = 3'd1;
  localparam ST_ERASE = 3'd2;
  localparam ST_EVAL = 3'd3;
  localparam ST_ACK = 3'd4;
  localparam V_NONE = 3'd0;
  localparam V_EQ = 3'd1;
  localparam V_SGN = 3'd2;
  localparam V_DIG = 3'd3;
  localparam V_DONE = 3'd4;
  localparam V_BAD = 3'd5;

  function is_digit;
    input [7:0] c;
    is_digit = (c >= `MRB_CH_0) && (c <= `MRB_CH_9);
  endfunction

  function is_num_char;
    input [7:0] c;
    is_num_char = is_digit(c) || c == `MRB_CH_PLUS || c == `MRB_CH_COMMA ||
                  c == `MRB_CH_MINUS || c == `MRB_CH_STAR;
  endfunction

  // Command is stored last character in byte 0, so it lines up with the window
  function cmd_hit;
    input [63:0] win;
    input [63:0] cmd;
    input [3:0] len;
    integer b;
    begin
      cmd_hit = (len != 4'h0) && (len <= 4'h8);
      for (b = 0; b < 8; b = b + 1) begin
        if (b < len && win[b*8 +: 8] != cmd[b*8 +: 8])
          cmd_hit = 1'b0;
      end
    end
  endfunction

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer b;
    begin
      merge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b])
          merge[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
  endfunction

  function reg_ok;
    input [7:0] a;
    reg [5:0] i;
    begin
      i = a[7:2];
      reg_ok = (i <= `MRB_A_STAT >> 2) || (i >= `MRB_A_NUM0 >> 2 && i <= `MRB_A_NUM6 >> 2) ||
               (i >= `MRB_A_CON0 >> 2 && i <= `MRB_A_COF1 >> 2);
    end
  endfunction

  reg [3:0] ctrl_r;
  reg [9:0] age_r;
  reg [31:0] limit_r;
  reg [15:0] pass_r;
  reg [4:0] nlen_r;
  reg [7:0] clen_r;
  reg [223:0] num_r;
  reg [63:0] con_r;
  reg [63:0] cof_r;
  reg [7:0] aw_r;
  reg aw_got_r;
  reg [31:0] wd_r;
  reg [3:0] ws_r;
  reg w_got_r;
  reg [3:0] s1_r;
  reg [3:0] s2_r;
  reg [2:0] st_r;
  reg [4:0] sidx_r;
  reg mism_r;
  reg wild_r;
  reg [2:0] tidx_r;
  reg pwbad_r;
  reg [63:0] win_r;
  reg [1:0] act_r;
  reg seen_r;
  reg [2:0] vst_r;
  reg [16:0] mag_r;
  reg neg_r;
  reg ovf_r;
  reg aged_r;
  reg [1:0] last_code_r;
  reg apply_r;
  reg [31:0] rd_nxt;
  reg [31:0] wr_old;
  reg num_good;
  integer k;

  wire en_s = s2_r[0];
  wire rin_s = s2_r[1];
  wire run_s = s2_r[2];
  wire pwr_s = s2_r[3];
  wire word_mode = ctrl_r[`MRB_C_WORD];
  wire [31:0] wr_new = merge(wr_old, wd_r, ws_r);
  wire tk = MSG_VALID && MSG_READY;
  wire [7:0] pc = num_r[{sidx_r, 3'b000} +: 8];
  wire [63:0] win_nxt = {win_r[55:0], MSG_CHAR};
  wire on_hit = cmd_hit(win_nxt, con_r, clen_r[3:0]);
  wire off_hit = cmd_hit(win_nxt, cof_r, clen_r[7:4]);
  wire [3:0] dig = MSG_CHAR[3:0];
  wire [16:0] mag10 = {mag_r[13:0], 3'b000} + {mag_r[15:0], 1'b0} + {13'h0000, dig};
  wire [13:0] unit = (age_r[9:8] == 2'd0) ? `MRB_U_MIN : (age_r[9:8] == 2'd1) ? `MRB_U_HALF :
                     (age_r[9:8] == 2'd2) ? `MRB_U_DAY : `MRB_U_WEEK;
  wire [21:0] age_lim = age_r[7:0] * unit;
  wire [16:0] sval = neg_r ? (17'h00000 - mag_r) : mag_r;
  wire [16:0] up17 = {limit_r[31], limit_r[31:16]};
  wire [16:0] lo17 = {limit_r[15], limit_r[15:0]};
  wire [16:0] clamp = ($signed(sval) > $signed(up17)) ? up17 :
                      ($signed(sval) < $signed(lo17)) ? lo17 : sval;
  wire val_ok = (vst_r == V_DIG || vst_r == V_DONE) && !ovf_r &&
                (neg_r ? mag_r <= 17'h08000 : mag_r <= 17'h07fff);
  // trailing star needs at least one more character, otherwise exact length
  wire sender_ok = !mism_r && num_good && nlen_r != 5'h00 && (wild_r || sidx_r == nlen_r);
  wire cmd_err = word_mode ? !(seen_r && val_ok) : (act_r == 2'b00);

  // Sender pattern may only hold the allowed character set
  always @* begin
    num_good = (nlen_r <= 5'd28);
    for (k = 0; k < 28; k = k + 1) begin
      if (k < nlen_r && !is_num_char(num_r[k*8 +: 8]))
        num_good = 1'b0;
    end
  end

  always @(posedge CLK_SYS) begin
    if (RST) begin
      s1_r <= 4'h0;
      s2_r <= 4'h0;
    end else begin
      s1_r <= {PWR_RESTORE, RUN, RESET_IN, ENABLE};
      s2_r <= s1_r;
    end
  end

  // Old contents of the addressed register, so byte strobes keep the untouched bytes
  always @* begin
    case ({aw_r[7:2], 2'b00})
      `MRB_A_CTRL: wr_old = {28'h0000000, ctrl_r};
      `MRB_A_AGE: wr_old = {22'h000000, age_r};
      `MRB_A_LIMIT: wr_old = limit_r;
      `MRB_A_PASS: wr_old = {16'h0000, pass_r};
      `MRB_A_NLEN: wr_old = {27'h0000000, nlen_r};
      `MRB_A_CLEN: wr_old = {24'h000000, clen_r};
      `MRB_A_CON0: wr_old = con_r[31:0];
      `MRB_A_CON1: wr_old = con_r[63:32];
      `MRB_A_COF0: wr_old = cof_r[31:0];
      `MRB_A_COF1: wr_old = cof_r[63:32];
      default: wr_old = num_r[{aw_r[4:2], 5'b00000} +: 32];
    endcase
  end

  // Register write: address and data may arrive in either order
  always @(posedge CLK_SYS) begin
    if (RST) begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `MRB_RESP_OK;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_r <= 8'h00;
      wd_r <= 32'h00000000;
      ws_r <= 4'h0;
      ctrl_r <= `MRB_RST_CTRL;
      age_r <= `MRB_RST_AGE;
      limit_r <= `MRB_RST_LIMIT;
      pass_r <= `MRB_RST_PASS;
      nlen_r <= 5'h00;
      clen_r <= 8'h00;
      num_r <= {224{1'b0}};
      con_r <= 64'h0000000000000000;
      cof_r <= 64'h0000000000000000;
    end else begin
      S_AXI_AWREADY <= !aw_got_r && !(S_AXI_AWVALID && S_AXI_AWREADY) && !S_AXI_BVALID;
      S_AXI_WREADY <= !w_got_r && !(S_AXI_WVALID && S_AXI_WREADY) && !S_AXI_BVALID;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_r <= S_AXI_AWADDR;
        aw_got_r <= 1'b1;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        wd_r <= S_AXI_WDATA;
        ws_r <= S_AXI_WSTRB;
        w_got_r <= 1'b1;
      end
      if (S_AXI_BVALID && S_AXI_BREADY)
        S_AXI_BVALID <= 1'b0;
      if (aw_got_r && w_got_r && !S_AXI_BVALID) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= reg_ok(aw_r) ? `MRB_RESP_OK : `MRB_RESP_SLV;
        case ({aw_r[7:2], 2'b00})
          `MRB_A_CTRL: ctrl_r <= wr_new[3:0];
          `MRB_A_AGE: age_r <= wr_new[9:0];
          `MRB_A_LIMIT: limit_r <= wr_new;
          `MRB_A_PASS: pass_r <= wr_new[15:0];
          `MRB_A_NLEN: nlen_r <= wr_new[4:0];
          `MRB_A_CLEN: clen_r <= wr_new[7:0];
          `MRB_A_CON0: con_r[31:0] <= wr_new;
          `MRB_A_CON1: con_r[63:32] <= wr_new;
          `MRB_A_COF0: cof_r[31:0] <= wr_new;
          `MRB_A_COF1: cof_r[63:32] <= wr_new;
          default: begin
            if (aw_r[7:2] >= (`MRB_A_NUM0 >> 2) && aw_r[7:2] <= (`MRB_A_NUM6 >> 2))
              num_r[{aw_r[4:2], 5'b00000} +: 32] <= wr_new;
          end
        endcase
      end
    end
  end

  always @* begin
    case ({S_AXI_ARADDR[7:2], 2'b00})
      `MRB_A_CTRL: rd_nxt = {28'h0000000, ctrl_r};
      `MRB_A_AGE: rd_nxt = {22'h000000, age_r};
      `MRB_A_LIMIT: rd_nxt = limit_r;
      `MRB_A_PASS: rd_nxt = {16'h0000, pass_r};
      `MRB_A_NLEN: rd_nxt = {27'h0000000, nlen_r};
      `MRB_A_CLEN: rd_nxt = {24'h000000, clen_r};
      `MRB_A_STAT: rd_nxt = {WORD_OUT, 8'h00, num_good, st_r, last_code_r, st_r != ST_IDLE, BIT_OUT};
      `MRB_A_CON0: rd_nxt = con_r[31:0];
      `MRB_A_CON1: rd_nxt = con_r[63:32];
      `MRB_A_COF0: rd_nxt = cof_r[31:0];
      `MRB_A_COF1: rd_nxt = cof_r[63:32];
      default: begin
        rd_nxt = 32'h00000000;
        if (S_AXI_ARADDR[7:2] >= (`MRB_A_NUM0 >> 2) && S_AXI_ARADDR[7:2] <= (`MRB_A_NUM6 >> 2))
          rd_nxt = num_r[{S_AXI_ARADDR[4:2], 5'b00000} +: 32];
      end
    endcase
  end

  always @(posedge CLK_SYS) begin
    if (RST) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h00000000;
      S_AXI_RRESP <= `MRB_RESP_OK;
    end else begin
      S_AXI_ARREADY <= !S_AXI_RVALID && !(S_AXI_ARVALID && S_AXI_ARREADY);
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA <= rd_nxt;
        S_AXI_RRESP <= reg_ok(S_AXI_ARADDR) ? `MRB_RESP_OK : `MRB_RESP_SLV;
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  // Message sequence; parsing runs on the fly so no text buffer is needed
  always @(posedge CLK_SYS) begin
    if (RST) begin
      st_r <= ST_IDLE;
      XFER_REQ <= 1'b0;
      ERASE_REQ <= 1'b0;
      MSG_READY <= 1'b0;
      ACK_VALID <= 1'b0;
      ACK_CODE <= `MRB_ACK_OK;
      last_code_r <= `MRB_ACK_OK;
      apply_r <= 1'b0;
      sidx_r <= 5'h00;
      mism_r <= 1'b0;
      wild_r <= 1'b0;
      tidx_r <= 3'h0;
      pwbad_r <= 1'b0;
      win_r <= 64'h0000000000000000;
      act_r <= 2'b00;
      seen_r <= 1'b0;
      vst_r <= V_NONE;
      mag_r <= 17'h00000;
      neg_r <= 1'b0;
      ovf_r <= 1'b0;
      aged_r <= 1'b0;
    end else begin
      XFER_REQ <= 1'b0;
      ERASE_REQ <= 1'b0;
      apply_r <= 1'b0;
      case (st_r)
        ST_IDLE: begin
          if (MSG_NEW) begin
            XFER_REQ <= 1'b1;
            MSG_READY <= 1'b1;
            st_r <= ST_RECV;
            sidx_r <= 5'h00;
            mism_r <= 1'b0;
            wild_r <= 1'b0;
            tidx_r <= 3'h0;
            pwbad_r <= 1'b0;
            win_r <= 64'h0000000000000000;
            act_r <= 2'b00;
            seen_r <= 1'b0;
            vst_r <= V_NONE;
            ovf_r <= 1'b0;
          end
        end
        ST_RECV: begin
          if (tk && !MSG_FIELD) begin
            if (sidx_r != 5'h1f)
              sidx_r <= sidx_r + 5'h01;
            if (!wild_r) begin
              if (sidx_r >= nlen_r)
                mism_r <= 1'b1;
              else if (pc == `MRB_CH_STAR && sidx_r == nlen_r - 5'h01)
                wild_r <= 1'b1;
              else if (pc != MSG_CHAR)
                mism_r <= 1'b1;
            end
          end
          if (tk && MSG_FIELD) begin
            win_r <= win_nxt;
            if (tidx_r != 3'h4) begin
              tidx_r <= tidx_r + 3'h1;
              if (MSG_CHAR != {4'h3, pass_r[{~tidx_r[1:0], 2'b00} +: 4]})
                pwbad_r <= 1'b1;
            end
            if (word_mode && on_hit) begin
              seen_r <= 1'b1;
              vst_r <= V_EQ;
              mag_r <= 17'h00000;
              neg_r <= 1'b0;
              ovf_r <= 1'b0;
            end else if (!word_mode && (on_hit || off_hit)) begin
              act_r <= on_hit ? 2'b01 : 2'b10;
            end else begin
              case (vst_r)
                V_EQ: vst_r <= (MSG_CHAR == `MRB_CH_EQ) ? V_SGN : V_BAD;
                V_SGN: begin
                  if (MSG_CHAR == `MRB_CH_MINUS && !neg_r) begin
                    neg_r <= 1'b1;
                  end else if (is_digit(MSG_CHAR)) begin
                    mag_r <= {13'h0000, dig};
                    vst_r <= V_DIG;
                  end else begin
                    vst_r <= V_BAD;
                  end
                end
                V_DIG: begin
                  if (is_digit(MSG_CHAR)) begin
                    if (mag_r > 17'd3277)
                      ovf_r <= 1'b1;
                    else
                      mag_r <= mag10;
                  end else begin
                    vst_r <= V_DONE;
                  end
                end
                default: vst_r <= vst_r;
              endcase
            end
          end
          if (tk && MSG_LAST) begin
            MSG_READY <= 1'b0;
            aged_r <= {2'b00, MSG_AGE} > age_lim;
            st_r <= ST_ERASE;
          end
        end
        ST_ERASE: begin
          ERASE_REQ <= 1'b1;
          st_r <= ST_EVAL;
        end
        ST_EVAL: begin
          if (!sender_ok || (ctrl_r[`MRB_C_PWP] && (pwbad_r || tidx_r != 3'h4)))
            ACK_CODE <= `MRB_ACK_NOACC;
          else if (cmd_err)
            ACK_CODE <= `MRB_ACK_ERR;
          else
            ACK_CODE <= `MRB_ACK_OK;
          if (aged_r) begin
            st_r <= ST_IDLE;
          end else begin
            if (sender_ok && !(ctrl_r[`MRB_C_PWP] && (pwbad_r || tidx_r != 3'h4)) && !cmd_err)
              apply_r <= 1'b1;
            if (ctrl_r[`MRB_C_ACK] && run_s) begin
              ACK_VALID <= 1'b1;
              st_r <= ST_ACK;
            end else begin
              st_r <= ST_IDLE;
            end
          end
        end
        ST_ACK: begin
          last_code_r <= ACK_CODE;
          if (ACK_READY) begin
            ACK_VALID <= 1'b0;
            st_r <= ST_IDLE;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // Reset input wins over everything; enable low freezes the outputs, but power restore without retention still clears them
  always @(posedge CLK_SYS) begin
    if (RST) begin
      BIT_OUT <= 1'b0;
      WORD_OUT <= 16'h0000;
    end else if (rin_s) begin
      BIT_OUT <= 1'b0;
      WORD_OUT <= 16'h0000;
    end else if (pwr_s && !ctrl_r[`MRB_C_RET]) begin
      BIT_OUT <= 1'b0;
      WORD_OUT <= 16'h0000;
    end else if (apply_r && en_s) begin
      if (word_mode)
        WORD_OUT <= clamp[15:0];
      else if (act_r == 2'b01)
        BIT_OUT <= 1'b1;
      else
        BIT_OUT <= 1'b0;
    end
  end
endmodule // mrb_top
`default_nettype wire

// ==== tb/mrb_chk_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module mrb_chk (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic S_AXI_RVALID,
  input wire logic ENABLE,
  input wire logic RESET_IN,
  input wire logic PWR_RESTORE,
  input wire logic XFER_REQ,
  input wire logic MSG_VALID,
  input wire logic MSG_READY,
  input wire logic MSG_LAST,
  input wire logic ERASE_REQ,
  input wire logic ACK_VALID,
  input wire logic [1:0] ACK_CODE,
  input wire logic ACK_READY,
  input wire logic BIT_OUT,
  input wire logic [15:0] WORD_OUT
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);
  property p_xfer;
    $rose(MSG_READY) |-> XFER_REQ ##1 !XFER_REQ;
  endproperty
  a_xfer: assert property (p_xfer) else $error("transfer request not paired with ready");
  property p_erase;
    MSG_VALID && MSG_READY && MSG_LAST |=> !MSG_READY ##1 ERASE_REQ ##1 !ERASE_REQ;
  endproperty
  a_erase: assert property (p_erase) else $error("erase not two cycles after last char");
  property p_ackord;
    $rose(ACK_VALID) |-> $past(ERASE_REQ);
  endproperty
  a_ackord: assert property (p_ackord) else $error("reply before erase");
  property p_ackhold;
    ACK_VALID && !ACK_READY |=> ACK_VALID && $stable(ACK_CODE);
  endproperty
  a_ackhold: assert property (p_ackhold) else $error("reply dropped or changed");
  // Pin synchronisers need a few cycles before the output reacts
  property p_rst;
    RESET_IN [*5] |-> !BIT_OUT && WORD_OUT == 16'h0000;
  endproperty
  a_rst: assert property (p_rst) else $error("reset pin did not clear outputs");
  property p_hold;
    (!ENABLE && !RESET_IN && !PWR_RESTORE) [*5] |=> $stable(BIT_OUT) && $stable(WORD_OUT);
  endproperty
  a_hold: assert property (p_hold) else $error("output moved while disabled");
  property p_bresp;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID;
  endproperty
  a_bresp: assert property (p_bresp) else $error("write response late");
  property p_rdata;
    S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY;
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data late");
endmodule // mrb_chk
`default_nettype wire

// ==== tb/mrb_modem.sv ====
`timescale 1ns/1ps
`default_nettype none
module mrb_modem (
  input wire logic clk,
  input wire logic xfer_req,
  input wire logic msg_ready,
  input wire logic erase_req,
  input wire logic ack_valid,
  input wire logic [1:0] ack_code,
  output logic msg_new,
  output logic msg_valid,
  output logic msg_field,
  output logic [7:0] msg_char,
  output logic msg_last,
  output logic [19:0] msg_age,
  output logic ack_ready
);
  int fails;
  int ack_lag;
  initial begin
    msg_new = 1'b0;
    msg_valid = 1'b0;
    msg_field = 1'b0;
    msg_char = 8'h00;
    msg_last = 1'b0;
    msg_age = 20'h0;
    ack_ready = 1'b0;
  end
  // Code 4 returned means no reply came
  task send(input string s, t, input logic [19:0] g, output logic [2:0] c);
    int n;
    string m;
    m = {s, t};
    n = 0;
    msg_new <= 1'b1;
    do begin @(posedge clk); n++; end while (!xfer_req && n < 20);
    msg_new <= 1'b0;
    for (int i = 0; i < m.len(); i++) begin
      msg_valid <= 1'b1;
      msg_field <= (i >= s.len());
      msg_char <= m[i];
      msg_last <= (i == m.len() - 1);
      msg_age <= g;
      do begin @(posedge clk); n++; end while (!msg_ready && n < 200);
    end
    // Released data lines toggle so stale values cannot be trusted
    msg_valid <= 1'b0;
    msg_last <= 1'b0;
    msg_char <= ~msg_char;
    do begin @(posedge clk); n++; end while (!erase_req && n < 220);
    if (n >= 200) fails++;
    c = 3'h4;
    for (int k = 0; k < 10; k++) begin
      @(posedge clk);
      if (ack_valid && c[2] && k >= ack_lag) begin
        c = {1'b0, ack_code};
        ack_ready <= 1'b1;
      end else ack_ready <= 1'b0;
    end
  endtask
endmodule // mrb_modem
`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "mrb_regs.vh"
module testbench;
  localparam logic [2:0] OK = 3'h0, ER = 3'h1, NA = 3'h2, NO = 3'h4, DC = 3'h7;
  localparam logic [1:0] OKR = `MRB_RESP_OK;
  logic CLK_SYS, RST, ENABLE, RESET_IN, RUN, PWR_RESTORE, MSG_NEW, MSG_VALID, MSG_FIELD, MSG_LAST;
  logic XFER_REQ, MSG_READY, ERASE_REQ, ACK_VALID, ACK_READY, BIT_OUT;
  logic S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY;
  logic S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
  logic [7:0] S_AXI_AWADDR, S_AXI_ARADDR, MSG_CHAR;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
  logic [3:0] S_AXI_WSTRB;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, ACK_CODE;
  logic [19:0] MSG_AGE;
  logic [15:0] WORD_OUT;
  logic wmode;
  int err_total, cmp_count;
  mrb_top mrb_top_i (.CLK_SYS, .RST, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA,
    .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY,
    .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID,
    .S_AXI_RREADY, .ENABLE, .RESET_IN, .RUN, .PWR_RESTORE, .MSG_NEW, .XFER_REQ, .MSG_VALID,
    .MSG_READY, .MSG_FIELD, .MSG_CHAR, .MSG_LAST, .MSG_AGE, .ERASE_REQ, .ACK_VALID, .ACK_CODE,
    .ACK_READY, .BIT_OUT, .WORD_OUT);
  mrb_modem mrb_modem_i (.clk(CLK_SYS), .xfer_req(XFER_REQ), .msg_ready(MSG_READY),
    .erase_req(ERASE_REQ), .ack_valid(ACK_VALID), .ack_code(ACK_CODE), .msg_new(MSG_NEW),
    .msg_valid(MSG_VALID), .msg_field(MSG_FIELD), .msg_char(MSG_CHAR), .msg_last(MSG_LAST),
    .msg_age(MSG_AGE), .ack_ready(ACK_READY));
  always #2.5 CLK_SYS = ~CLK_SYS;
  task end_of_test();
    if (err_total == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task hang();
    err_total++;
    end_of_test();
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("unexpected at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    int n;
    @(posedge CLK_SYS);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    n = 0;
    do begin
      @(posedge CLK_SYS);
      n++;
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
    end while (!S_AXI_BVALID && n < 40);
    S_AXI_BREADY <= 1'b0;
    if (n >= 40) hang();
    chk(S_AXI_BRESP, e);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    @(posedge CLK_SYS);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    n = 0;
    do begin
      @(posedge CLK_SYS);
      n++;
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
    end while (!S_AXI_RVALID && n < 40);
    S_AXI_RREADY <= 1'b0;
    if (n >= 40) hang();
    chk(S_AXI_RDATA, e);
    chk(S_AXI_RRESP, er);
  endtask
  task pins(input logic e, r, p);
    @(posedge CLK_SYS);
    ENABLE <= e;
    RESET_IN <= r;
    PWR_RESTORE <= p;
    repeat (6) @(posedge CLK_SYS);
  endtask
  // Reply code 7 leaves the reply unjudged
  task msg(input string s, t, input logic [19:0] g, input logic [2:0] c, input logic [15:0] o);
    logic [2:0] a;
    mrb_modem_i.send(s, t, g, a);
    if (c != DC) chk(a, c);
    chk(wmode ? WORD_OUT : {15'h0, BIT_OUT}, o);
  endtask
  task t_regs();
    rd(`MRB_A_CTRL, 32'h0, OKR);
    rd(`MRB_A_AGE, 32'h1, OKR);
    rd(`MRB_A_LIMIT, 32'h7fff8000, OKR);
    rd(8'hfc, 32'h0, `MRB_RESP_SLV);
    wr(8'hfc, 32'h5, `MRB_RESP_SLV);
    wr(`MRB_A_STAT, 32'hffffffff, OKR);
  endtask
  task t_bit();
    wmode = 1'b0;
    wr(`MRB_A_CTRL, 32'h2, OKR);
    wr(`MRB_A_NUM0, 32'h3231, OKR);
    wr(`MRB_A_NLEN, 32'h2, OKR);
    wr(`MRB_A_CON0, 32'h4f4e, OKR);
    wr(`MRB_A_COF0, 32'h4f46, OKR);
    wr(`MRB_A_CLEN, 32'h22, OKR);
    msg("12", "ON", 20'h0, OK, 16'h1);
    msg("12", "xOFx", 20'h0, OK, 16'h0);
    msg("13", "ON", 20'h0, NA, 16'h0);
    msg("123", "ON", 20'h0, NA, 16'h0);
    msg("12", "ZZ", 20'h0, ER, 16'h0);
    msg("12", "ON", 20'h6, NO, 16'h0);
    msg("12", "ON", 20'h5, OK, 16'h1);
    wr(`MRB_A_AGE, 32'h302, OKR);
    msg("12", "OF", 20'h4ec1, NO, 16'h1);
    msg("12", "ON", 20'h4ec0, OK, 16'h1);
    pins(1'b0, 1'b0, 1'b0);
    msg("12", "OF", 20'h0, DC, 16'h1);
    pins(1'b0, 1'b1, 1'b0);
    chk(BIT_OUT, 1'b0);
    pins(1'b1, 1'b0, 1'b0);
    wr(`MRB_A_CTRL, 32'h0, OKR);
    msg("12", "ON", 20'h0, NO, 16'h1);
  endtask
  task t_star();
    wr(`MRB_A_CTRL, 32'h2, OKR);
    wr(`MRB_A_NUM0, 32'h2a31, OKR);
    msg("1", "OF", 20'h0, NA, 16'h1);
    msg("15", "OF", 20'h0, OK, 16'h0);
    wr(`MRB_A_NUM0, 32'h2a2b, OKR);
    msg("49", "ON", 20'h0, NA, 16'h0);
    msg("+49", "ON", 20'h0, OK, 16'h1);
    wr(`MRB_A_NUM0, 32'h4131, OKR);
    msg("1A", "OF", 20'h0, NA, 16'h1);
    rd(`MRB_A_STAT, 32'h00000009, OKR);
    wr(`MRB_A_NUM0, 32'h2a, OKR);
    wr(`MRB_A_NLEN, 32'h1, OKR);
    msg("765", "OF", 20'h0, OK, 16'h0);
  endtask
  task t_word();
    wmode = 1'b1;
    mrb_modem_i.ack_lag = 3;
    wr(`MRB_A_CTRL, 32'h3, OKR);
    wr(`MRB_A_NUM0, 32'h3231, OKR);
    wr(`MRB_A_NLEN, 32'h2, OKR);
    wr(`MRB_A_CON0, 32'h53, OKR);
    wr(`MRB_A_CLEN, 32'h1, OKR);
    wr(`MRB_A_LIMIT, 32'h0064fffb, OKR);
    msg("12", "S=40", 20'h0, OK, 16'h0028);
    msg("12", "S=200", 20'h0, OK, 16'h0064);
    msg("12", "S=-9", 20'h0, OK, 16'hfffb);
    msg("12", "S=-3", 20'h0, OK, 16'hfffd);
    msg("12", "Q=5", 20'h0, ER, 16'hfffd);
    wr(`MRB_A_CTRL, 32'hb, OKR);
    wr(`MRB_A_PASS, 32'h1234, OKR);
    msg("12", "1234S=7", 20'h0, OK, 16'h0007);
    msg("12", "1235S=9", 20'h0, NA, 16'h0007);
    wr(`MRB_A_CTRL, 32'hf, OKR);
    pins(1'b1, 1'b0, 1'b1);
    pins(1'b1, 1'b0, 1'b0);
    chk(WORD_OUT, 16'h0007);
    wr(`MRB_A_CTRL, 32'hb, OKR);
    pins(1'b1, 1'b0, 1'b1);
    pins(1'b1, 1'b0, 1'b0);
    chk(WORD_OUT, 16'h0000);
    msg("12", "1234S=9", 20'h0, OK, 16'h0009);
    RUN <= 1'b0;
    msg("12", "1234S=5", 20'h0, NO, 16'h0005);
    pins(1'b0, 1'b1, 1'b0);
    chk(WORD_OUT, 16'h0000);
  endtask
  initial begin
    CLK_SYS = 1'b0;
    RST = 1'b1;
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 5'h0;
    S_AXI_AWADDR = 8'h00;
    S_AXI_ARADDR = 8'h00;
    S_AXI_WDATA = 32'h0;
    S_AXI_WSTRB = 4'hf;
    {ENABLE, RESET_IN, RUN, PWR_RESTORE} = 4'ha;
    wmode = 1'b0;
    repeat (20) @(posedge CLK_SYS);
    RST <= 1'b0;
    t_regs();
    t_bit();
    t_star();
    t_word();
    chk(mrb_modem_i.fails, 32'h0);
    end_of_test();
  end
endmodule // testbench
bind mrb_top mrb_chk mrb_chk_i (.CLK_SYS, .RST, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID,
  .S_AXI_WREADY, .S_AXI_BVALID, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RVALID, .ENABLE,
  .RESET_IN, .PWR_RESTORE, .XFER_REQ, .MSG_VALID, .MSG_READY, .MSG_LAST, .ERASE_REQ,
  .ACK_VALID, .ACK_CODE, .ACK_READY, .BIT_OUT, .WORD_OUT);
`default_nettype wire
